// ### src/clk_pwr_pkg.sv
package clk_pwr_pkg;

  // register byte offsets
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFF_SRC_SEL = 6'h00;
  localparam logic [5:0] OFF_PLL_CTRL = 6'h04;
  localparam logic [5:0] OFF_PLL_CFG = 6'h08;
  localparam logic [5:0] OFF_PLL_STAT = 6'h0c;
  localparam logic [5:0] OFF_CPU_DIV = 6'h10;
  localparam logic [5:0] OFF_USB_DIV = 6'h14;
  localparam logic [5:0] OFF_PER_EN = 6'h18;
  localparam logic [5:0] OFF_PER_DIV = 6'h1c;
  localparam logic [5:0] OFF_OSC_CTRL = 6'h20;
  localparam logic [5:0] OFF_STATUS = 6'h24;
  localparam logic [5:0] OFF_PWR_CTRL = 6'h28;

  // clock source codes
  localparam logic [1:0] SRC_IRC = 2'h0;
  localparam logic [1:0] SRC_MAIN = 2'h1;
  localparam logic [1:0] SRC_RTC = 2'h2;
  localparam logic [1:0] SRC_BAD = 2'h3;

  // field positions
  localparam int PLL_EN_BIT = 0;
  localparam int PLL_CON_BIT = 1;
  localparam int PLL_LOCK_BIT = 2;
  localparam int CFG_N_LSB = 0;
  localparam int CFG_M_LSB = 8;
  localparam int MAIN_OK_BIT = 0;
  localparam int FLASH_RDY_BIT = 1;
  localparam int MODE_LSB = 4;
  localparam int PWR_IDLE_BIT = 0;
  localparam int PWR_SLEEP_BIT = 1;
  localparam int PWR_PDOWN_BIT = 2;
  localparam int PWR_DPDOWN_BIT = 3;

  // reset values
  localparam logic [7:0] RST_PRE_N = 8'h00;
  localparam logic [14:0] RST_MUL_M = 15'h0000;
  localparam logic [7:0] RST_CPU_DIV = 8'h00;
  localparam logic [3:0] RST_USB_DIV = 4'h0;
  localparam logic [7:0] RST_CCO_PER = 8'h10;

  // timing counts, in ticks of the named oscillator
  localparam int IRC_MHZ = 4;
  localparam int FLASH_START_US = 100;
  localparam logic [8:0] FLASH_WAKE_TICKS = 9'(FLASH_START_US * IRC_MHZ);
  localparam logic [12:0] SLEEP_WAKE_IRC = 13'h0004;
  localparam logic [12:0] SLEEP_WAKE_MAIN = 13'h1000;
  localparam logic [12:0] MAIN_STABLE_TICKS = 13'h1000;
  localparam logic [3:0] LOCK_REFS = 4'h8;

  // power modes
  typedef enum logic [5:0] {
    M_RUN = 6'b000001,
    M_IDLE = 6'b000010,
    M_SLEEP = 6'b000100,
    M_PDOWN = 6'b001000,
    M_DPDOWN = 6'b010000,
    M_WAKE = 6'b100000
  } mode_t;

endpackage

// ### src/clock_pll_power_control.sv
// Functional notes
// - reset always starts on internal RC oscillator
// - software picks any of three oscillators
// - cpu clock equals pll input unless connected and locked
// - pll pre-divider N from 1 to 256
// - feedback divides oscillator by M, detector steers
// - pll output divided for cpu and usb
// - reset and power-down disable, bypass the pll
// - wake from power-down resumes on internal RC
// - wake-up timer guards main oscillator use
// - wake-up timer runs after reset and wakes except from idle
// - idle, sleep, power-down, deep power-down modes
// - cpu clock passes a programmable divider
// - each peripheral clock can be stopped
// - each peripheral has its own divider
// - idle halts cpu until reset or interrupt
// - peripheral clocks keep running in idle
// - sleep wake waits 4 or 4096 cycles
// - sleep entry drops pll, clears both dividers
// - flash counter covers 100 us after reset and power-down wakes
`timescale 1ns/1ns
module clock_pll_power_control #(
  parameter int NP = 4
) (
  // clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // oscillator tick enables
  input wire logic IRC_TICK,
  input wire logic MAIN_OSC_TICK,
  input wire logic RTC_TICK,
  // wake-up interrupt
  input wire logic WAKE_IRQ,
  // avalon-mm slave
  input wire logic [clk_pwr_pkg::ADDR_W-1:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  // derived clock enables and status
  output logic CPU_CLK_EN,
  output logic USB_CLK_EN,
  output logic [NP-1:0] PERIPH_CLK_EN,
  output logic CPU_RUN,
  output logic FLASH_READY,
  output logic PLL_LOCKED
);

  if (NP < 1 || NP > 16) begin : g_np_check
    $error("NP must lie between 1 and 16");
  end

  typedef struct packed {
    logic [1:0] src_sel;
    logic main_en;
    logic pll_en;
    logic pll_con;
    logic [7:0] pre_n;
    logic [14:0] mul_m;
    logic [7:0] cpu_div;
    logic [3:0] usb_div;
    logic [NP-1:0] per_en;
    logic [NP-1:0][1:0] per_div;
    clk_pwr_pkg::mode_t mode;
    logic wake_main;
    logic [12:0] wake_cnt;
    logic [8:0] flash_cnt;
    logic flash_rdy;
    logic [12:0] main_cnt;
    logic main_ok;
    logic [7:0] pre_cnt;
    logic [14:0] fb_cnt;
    logic [7:0] cco_per;
    logic [7:0] cco_cnt;
    logic [1:0] fb_seen;
    logic [3:0] lock_cnt;
    logic [1:0] act_sel;
    logic act_pll;
    logic [7:0] cpu_cnt;
    logic [3:0] usb_cnt;
    logic [NP-1:0][2:0] per_cnt;
    logic cpu_en;
    logic usb_en;
    logic [NP-1:0] per_clk;
    logic waitreq;
    logic [31:0] rdata;
    logic run;
    logic lock_ok;
  } state_t;

  state_t q;
  state_t d;

  // value after any chip reset or deep power-down wake
  function automatic state_t rst_state();
    state_t r;
    r = '0;
    r.src_sel = clk_pwr_pkg::SRC_IRC;
    r.act_sel = clk_pwr_pkg::SRC_IRC;
    r.pre_n = clk_pwr_pkg::RST_PRE_N;
    r.mul_m = clk_pwr_pkg::RST_MUL_M;
    r.cpu_div = clk_pwr_pkg::RST_CPU_DIV;
    r.usb_div = clk_pwr_pkg::RST_USB_DIV;
    r.cco_per = clk_pwr_pkg::RST_CCO_PER;
    r.per_en = '1;
    r.mode = clk_pwr_pkg::M_WAKE;
    r.waitreq = 1'b1;
    return r; // pll off and bypassed
  endfunction

  logic pin_tick;
  logic ref_tick;
  logic cco_tick;
  logic fb_tick;
  logic locked;
  logic pll_live;
  logic src_tick;
  logic raw_cpu;
  logic per_run;
  logic wake_tick;
  logic [12:0] wake_lim;
  logic [31:0] rv;
  logic [31:0] wd;
  logic [2:0] per_lim;

  assign locked = (q.lock_cnt == clk_pwr_pkg::LOCK_REFS);
  assign pll_live = q.pll_en && q.pll_con && locked;

  // register readback for the addressed word
  always_comb begin
    rv = '0;
    unique case (ADDRESS)
      clk_pwr_pkg::OFF_SRC_SEL: rv[1:0] = q.src_sel;
      clk_pwr_pkg::OFF_PLL_CTRL: begin
        rv[clk_pwr_pkg::PLL_EN_BIT] = q.pll_en;
        rv[clk_pwr_pkg::PLL_CON_BIT] = q.pll_con;
      end
      clk_pwr_pkg::OFF_PLL_CFG: begin
        rv[clk_pwr_pkg::CFG_N_LSB +: 8] = q.pre_n;
        rv[clk_pwr_pkg::CFG_M_LSB +: 15] = q.mul_m;
      end
      clk_pwr_pkg::OFF_PLL_STAT: begin
        rv[clk_pwr_pkg::PLL_EN_BIT] = q.pll_en;
        rv[clk_pwr_pkg::PLL_CON_BIT] = q.act_pll;
        rv[clk_pwr_pkg::PLL_LOCK_BIT] = locked;
      end
      clk_pwr_pkg::OFF_CPU_DIV: rv[7:0] = q.cpu_div;
      clk_pwr_pkg::OFF_USB_DIV: rv[3:0] = q.usb_div;
      clk_pwr_pkg::OFF_PER_EN: rv[NP-1:0] = q.per_en;
      clk_pwr_pkg::OFF_PER_DIV: rv[2*NP-1:0] = q.per_div;
      clk_pwr_pkg::OFF_OSC_CTRL: rv[0] = q.main_en;
      clk_pwr_pkg::OFF_STATUS: begin
        rv[clk_pwr_pkg::MAIN_OK_BIT] = q.main_ok;
        rv[clk_pwr_pkg::FLASH_RDY_BIT] = q.flash_rdy;
        rv[clk_pwr_pkg::MODE_LSB +: 6] = q.mode;
      end
      clk_pwr_pkg::OFF_PWR_CTRL: rv[5:0] = q.mode;
      default: rv = '0;
    endcase
    for (int b = 0; b < 4; b++) begin
      wd[8*b +: 8] = BYTEENABLE[b] ? WRITEDATA[8*b +: 8] : rv[8*b +: 8];
    end
  end

  // next state of the whole block
  always_comb begin
    d = q;
    per_lim = '0;
    // main oscillator held off until the wake-up timer expires
    unique case (q.act_sel)
      clk_pwr_pkg::SRC_MAIN: pin_tick = MAIN_OSC_TICK && q.main_ok;
      clk_pwr_pkg::SRC_RTC: pin_tick = RTC_TICK;
      default: pin_tick = IRC_TICK;
    endcase

    // pre-divider feeding the phase detector
    ref_tick = 1'b0;
    if (q.pll_en && pin_tick) begin
      if (q.pre_cnt == q.pre_n) begin // divide by pre_n + 1
        ref_tick = 1'b1;
        d.pre_cnt = '0;
      end else begin
        d.pre_cnt = q.pre_cnt + 8'h01;
      end
    end

    // controlled oscillator and feedback divider
    cco_tick = 1'b0;
    fb_tick = 1'b0;
    if (q.pll_en) begin
      if (q.cco_cnt >= q.cco_per) begin
        cco_tick = 1'b1;
        d.cco_cnt = '0;
      end else begin
        d.cco_cnt = q.cco_cnt + 8'h01;
      end
    end
    if (cco_tick) begin
      if (q.fb_cnt == q.mul_m) begin // divide by mul_m + 1
        fb_tick = 1'b1;
        d.fb_cnt = '0;
      end else begin
        d.fb_cnt = q.fb_cnt + 15'h0001;
      end
    end
    if (fb_tick && q.fb_seen != 2'h2) begin
      d.fb_seen = q.fb_seen + 2'h1;
    end

    // phase detector: steer period and count matched periods
    if (ref_tick) begin
      d.fb_seen = {1'b0, fb_tick};
      if (q.fb_seen == 2'h0 && !fb_tick) begin
        if (q.cco_per != 8'h00) begin
          d.cco_per = q.cco_per - 8'h01;
        end
        d.lock_cnt = '0;
      end else if (q.fb_seen == 2'h2) begin
        if (q.cco_per != 8'hff) begin
          d.cco_per = q.cco_per + 8'h01;
        end
        d.lock_cnt = '0;
      end else if (!locked) begin
        d.lock_cnt = q.lock_cnt + 4'h1;
      end
    end
    if (!q.pll_en) begin
      d.lock_cnt = '0;
      d.fb_seen = '0;
      d.fb_cnt = '0;
      d.pre_cnt = '0;
    end

    // cpu divider; sources change at a period boundary unless the active one fails
    src_tick = q.act_pll ? cco_tick : pin_tick;
    raw_cpu = 1'b0;
    if (src_tick) begin
      if (q.cpu_cnt >= q.cpu_div) begin // divide by cpu_div + 1
        raw_cpu = 1'b1;
        d.cpu_cnt = '0;
        d.act_sel = q.src_sel;
        d.act_pll = pll_live;
      end else begin
        d.cpu_cnt = q.cpu_cnt + 8'h01;
      end
    end
    // an unready main oscillator emits nothing, but leaving a still-enabled pll can cut a pulse
    if ((q.act_pll && !pll_live) ||
        (!q.act_pll && q.act_sel == clk_pwr_pkg::SRC_MAIN && !q.main_ok)) begin
      d.act_pll = 1'b0;
      d.act_sel = q.src_sel;
      d.cpu_cnt = '0;
    end

    // gated clock enables
    per_run = (q.mode == clk_pwr_pkg::M_RUN) ||
              (q.mode == clk_pwr_pkg::M_IDLE);
    d.cpu_en = raw_cpu && (q.mode == clk_pwr_pkg::M_RUN);
    d.usb_en = 1'b0;
    if (cco_tick && per_run) begin
      if (q.usb_cnt >= q.usb_div) begin
        d.usb_en = 1'b1;
        d.usb_cnt = '0;
      end else begin
        d.usb_cnt = q.usb_cnt + 4'h1;
      end
    end
    for (int i = 0; i < NP; i++) begin
      per_lim = 3'((4'h1 << q.per_div[i]) - 4'h1);
      d.per_clk[i] = 1'b0;
      if (!q.per_en[i]) begin
        d.per_cnt[i] = '0;
      end else if (raw_cpu && per_run) begin
        if (q.per_cnt[i] >= per_lim) begin
          d.per_clk[i] = 1'b1;
          d.per_cnt[i] = '0;
        end else begin
          d.per_cnt[i] = q.per_cnt[i] + 3'h1;
        end
      end
    end

    // main oscillator wake-up timer
    if (!q.main_en) begin
      d.main_ok = 1'b0;
      d.main_cnt = '0;
    end else if (!q.main_ok && MAIN_OSC_TICK) begin
      d.main_cnt = q.main_cnt + 13'h0001;
      if (q.main_cnt == clk_pwr_pkg::MAIN_STABLE_TICKS - 13'h0001) begin
        d.main_ok = 1'b1;
      end
    end

    // flash start-up counter in internal RC ticks
    if (!q.flash_rdy && IRC_TICK) begin
      d.flash_cnt = q.flash_cnt + 9'h001;
      if (q.flash_cnt == clk_pwr_pkg::FLASH_WAKE_TICKS - 9'h001) begin
        d.flash_rdy = 1'b1;
      end
    end

    // power mode sequencing
    wake_tick = q.wake_main ? MAIN_OSC_TICK : IRC_TICK;
    wake_lim = q.wake_main ? clk_pwr_pkg::SLEEP_WAKE_MAIN
                           : clk_pwr_pkg::SLEEP_WAKE_IRC;
    unique case (q.mode)
      clk_pwr_pkg::M_IDLE: begin
        if (WAKE_IRQ) begin
          d.mode = clk_pwr_pkg::M_RUN;
        end
      end
      clk_pwr_pkg::M_SLEEP: begin
        if (WAKE_IRQ) begin
          d.mode = clk_pwr_pkg::M_WAKE;
          d.wake_cnt = '0;
        end
      end
      clk_pwr_pkg::M_PDOWN: begin
        if (WAKE_IRQ) begin
          d.mode = clk_pwr_pkg::M_WAKE;
          d.wake_cnt = '0;
          d.wake_main = 1'b0;
          d.src_sel = clk_pwr_pkg::SRC_IRC;
          d.act_sel = clk_pwr_pkg::SRC_IRC;
          d.flash_rdy = 1'b0;
          d.flash_cnt = '0;
        end
      end
      clk_pwr_pkg::M_DPDOWN: begin
        if (WAKE_IRQ) begin
          d = rst_state();
          d.rdata = q.rdata; // bus data stands until the next access
        end
      end
      clk_pwr_pkg::M_WAKE: begin
        if (wake_tick) begin
          d.wake_cnt = q.wake_cnt + 13'h0001;
          if (q.wake_cnt == wake_lim - 13'h0001) begin
            d.mode = clk_pwr_pkg::M_RUN;
          end
        end
      end
      default: ;
    endcase

    // avalon-mm: answer one cycle after the request is seen
    if (q.waitreq && (READ || WRITE)) begin
      d.waitreq = 1'b0;
      d.rdata = rv;
    end else if (!q.waitreq) begin
      d.waitreq = 1'b1;
      if (WRITE) begin
        unique case (ADDRESS)
          clk_pwr_pkg::OFF_SRC_SEL: begin
            if (wd[1:0] != clk_pwr_pkg::SRC_BAD) begin
              d.src_sel = wd[1:0];
            end
          end
          clk_pwr_pkg::OFF_PLL_CTRL: begin
            d.pll_en = wd[clk_pwr_pkg::PLL_EN_BIT];
            d.pll_con = wd[clk_pwr_pkg::PLL_CON_BIT];
          end
          clk_pwr_pkg::OFF_PLL_CFG: begin
            d.pre_n = wd[clk_pwr_pkg::CFG_N_LSB +: 8];
            d.mul_m = wd[clk_pwr_pkg::CFG_M_LSB +: 15];
            d.lock_cnt = '0;
          end
          clk_pwr_pkg::OFF_CPU_DIV: d.cpu_div = wd[7:0];
          clk_pwr_pkg::OFF_USB_DIV: d.usb_div = wd[3:0];
          clk_pwr_pkg::OFF_PER_EN: d.per_en = wd[NP-1:0];
          clk_pwr_pkg::OFF_PER_DIV: d.per_div = wd[2*NP-1:0];
          clk_pwr_pkg::OFF_OSC_CTRL: d.main_en = wd[0];
          clk_pwr_pkg::OFF_PWR_CTRL: begin
            if (q.mode == clk_pwr_pkg::M_RUN) begin
              if (wd[clk_pwr_pkg::PWR_DPDOWN_BIT]) begin
                d.mode = clk_pwr_pkg::M_DPDOWN;
              end else if (wd[clk_pwr_pkg::PWR_PDOWN_BIT]) begin
                d.mode = clk_pwr_pkg::M_PDOWN;
                d.main_en = 1'b0;
              end else if (wd[clk_pwr_pkg::PWR_SLEEP_BIT]) begin
                d.mode = clk_pwr_pkg::M_SLEEP;
                d.wake_main = (q.act_sel == clk_pwr_pkg::SRC_MAIN);
              end else if (wd[clk_pwr_pkg::PWR_IDLE_BIT]) begin
                d.mode = clk_pwr_pkg::M_IDLE;
              end
              if (wd[clk_pwr_pkg::PWR_DPDOWN_BIT] ||
                  wd[clk_pwr_pkg::PWR_PDOWN_BIT] ||
                  wd[clk_pwr_pkg::PWR_SLEEP_BIT]) begin
                d.pll_en = 1'b0;
                d.pll_con = 1'b0;
                d.act_pll = 1'b0;
                d.cpu_div = '0;
                d.usb_div = '0;
                d.cpu_cnt = '0;
              end
            end
          end
          default: ;
        endcase
      end
    end

    // registered copies of the status outputs
    d.run = (d.mode == clk_pwr_pkg::M_RUN);
    d.lock_ok = (d.lock_cnt == clk_pwr_pkg::LOCK_REFS);
  end

  // single state register
  always_ff @(posedge CLK) begin
    if (SRST) begin
      q <= rst_state();
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign READDATA = q.rdata;
  assign WAITREQUEST = q.waitreq;
  assign CPU_CLK_EN = q.cpu_en;
  assign USB_CLK_EN = q.usb_en;
  assign PERIPH_CLK_EN = q.per_clk;
  assign CPU_RUN = q.run;
  assign FLASH_READY = q.flash_rdy;
  assign PLL_LOCKED = q.lock_ok;

endmodule

// ### tb/clk_pwr_checker.sv
`timescale 1ns/1ns
module clk_pwr_checker #(
  parameter int NP = 4
) (
  // clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // oscillator ticks and wake
  input wire logic IRC_TICK,
  input wire logic MAIN_OSC_TICK,
  input wire logic RTC_TICK,
  input wire logic WAKE_IRQ,
  // register bus
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] READDATA,
  input wire logic WAITREQUEST,
  // clock enables and status
  input wire logic CPU_CLK_EN,
  input wire logic [NP-1:0] PERIPH_CLK_EN,
  input wire logic CPU_RUN,
  input wire logic FLASH_READY,
  input wire logic PLL_LOCKED
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  // reset silences every enable and holds the bus off
  a_reset_quiet: assert property (disable iff (1'b0)
    SRST |=> WAITREQUEST && !CPU_RUN && !FLASH_READY && !CPU_CLK_EN
      && PERIPH_CLK_EN == '0)
    else $error("enables active after reset");
  // bus answers one cycle after a request is taken
  a_bus_answer: assert property (
    (READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
    else $error("bus answer late");
  a_bus_single: assert property (!WAITREQUEST |=> WAITREQUEST)
    else $error("bus answer held too long");
  a_bus_idle: assert property (
    !READ && !WRITE && WAITREQUEST |=> WAITREQUEST)
    else $error("bus answer without request");
  a_read_hold: assert property (
    WAITREQUEST && $past(WAITREQUEST) |-> $stable(READDATA))
    else $error("read data changed between accesses");
  // without the pll every cpu and peripheral pulse follows an oscillator tick
  a_cpu_cause: assert property (CPU_CLK_EN && !PLL_LOCKED |->
    $past(IRC_TICK) || $past(MAIN_OSC_TICK) || $past(RTC_TICK))
    else $error("cpu pulse without source tick");
  a_periph_cause: assert property (
    (|PERIPH_CLK_EN) && !PLL_LOCKED |->
    $past(IRC_TICK) || $past(MAIN_OSC_TICK) || $past(RTC_TICK))
    else $error("peripheral pulse without source tick");
  a_halt_cpu: assert property (
    !CPU_RUN && !$past(CPU_RUN) |-> !CPU_CLK_EN)
    else $error("cpu pulse while halted");
  a_run_cause: assert property ($rose(CPU_RUN) |->
    $past(IRC_TICK) || $past(MAIN_OSC_TICK) || $past(WAKE_IRQ)
      || $past(WAKE_IRQ, 2))
    else $error("cpu resumed without cause");
  a_flash_tick: assert property (
    $rose(FLASH_READY) |-> $past(IRC_TICK))
    else $error("flash ready without rc tick");
endmodule

bind clock_pll_power_control clk_pwr_checker #(.NP(NP)) chk_u (
  .CLK(CLK),
  .SRST(SRST),
  .IRC_TICK(IRC_TICK),
  .MAIN_OSC_TICK(MAIN_OSC_TICK),
  .RTC_TICK(RTC_TICK),
  .WAKE_IRQ(WAKE_IRQ),
  .READ(READ),
  .WRITE(WRITE),
  .READDATA(READDATA),
  .WAITREQUEST(WAITREQUEST),
  .CPU_CLK_EN(CPU_CLK_EN),
  .PERIPH_CLK_EN(PERIPH_CLK_EN),
  .CPU_RUN(CPU_RUN),
  .FLASH_READY(FLASH_READY),
  .PLL_LOCKED(PLL_LOCKED)
);

// ### tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  // design ports
  logic CLK = 0;
  logic SRST = 1;
  logic IRC_TICK = 0, MAIN_OSC_TICK = 0, RTC_TICK = 0, WAKE_IRQ = 0;
  logic [clk_pwr_pkg::ADDR_W-1:0] ADDRESS = '0;
  logic READ = 0, WRITE = 0;
  logic [31:0] WRITEDATA = '0;
  logic [3:0] BYTEENABLE = 4'hf;
  logic [31:0] READDATA;
  logic WAITREQUEST, CPU_CLK_EN, USB_CLK_EN, CPU_RUN;
  logic FLASH_READY, PLL_LOCKED;
  logic [3:0] PERIPH_CLK_EN;
  // model state
  int mismatches = 0, checked = 0, seed = 99, r, gen = 1, src = 0;
  int nt, nc, nu, wc, fc;
  int np [4];
  logic [31:0] q;

  clock_pll_power_control #(.NP(4)) dut_u (
    .CLK(CLK), .SRST(SRST), .IRC_TICK(IRC_TICK),
    .MAIN_OSC_TICK(MAIN_OSC_TICK), .RTC_TICK(RTC_TICK),
    .WAKE_IRQ(WAKE_IRQ), .ADDRESS(ADDRESS), .READ(READ),
    .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE),
    .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
    .CPU_CLK_EN(CPU_CLK_EN), .USB_CLK_EN(USB_CLK_EN),
    .PERIPH_CLK_EN(PERIPH_CLK_EN), .CPU_RUN(CPU_RUN),
    .FLASH_READY(FLASH_READY), .PLL_LOCKED(PLL_LOCKED)
  );

  always #2 CLK = ~CLK;

  // random oscillator ticks, never two in a row
  always @(posedge CLK) begin
    r = $random(seed);
    IRC_TICK <= gen != 0 && !IRC_TICK && r[1:0] == 2'h0;
    MAIN_OSC_TICK <= gen != 0 && !MAIN_OSC_TICK && r[2];
    RTC_TICK <= gen != 0 && !RTC_TICK && r[7:5] == 3'h0;
  end

  // reference counts of source ticks and output pulses
  always @(posedge CLK) begin
    if (SRST) begin
      wc = 0;
      fc = 0;
    end else begin
      if (IRC_TICK && CPU_RUN !== 1'b1) wc++;
      if (IRC_TICK && FLASH_READY !== 1'b1) fc++;
    end
    if ((src == 0 && IRC_TICK) || (src == 2 && RTC_TICK)) nt++;
    if (src == 1 && MAIN_OSC_TICK) nt++;
    if (CPU_CLK_EN === 1'b1) nc++;
    if (USB_CLK_EN === 1'b1) nu++;
    for (int i = 0; i < 4; i++) if (PERIPH_CLK_EN[i] === 1'b1) np[i]++;
  end

  task chk(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // divided counts may gain or lose one at the window edges
  task near(input int e, input int g);
    chk(e, (g == e + 1 || g == e - 1) ? e : g);
  endtask

  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    READ <= !w;
    WRITE <= w;
    ADDRESS <= a;
    WRITEDATA <= d;
    do begin
      @(posedge CLK);
      n++;
    end while (WAITREQUEST !== 1'b0 && n < 50);
    q = READDATA;
    READ <= 0;
    WRITE <= 0;
    if (n >= 50) chk(0, n);
  endtask

  task rd(input logic [5:0] a, input logic [31:0] e);
    bus(0, a, 0);
    chk(e, q);
  endtask

  task wr(input logic [5:0] a, input logic [31:0] d);
    bus(1, a, d);
  endtask

  // count ticks and pulses over a quiet-edged window
  task measure(input int n);
    gen = 0;
    repeat (6) @(posedge CLK);
    nt = 0;
    nc = 0;
    nu = 0;
    np = '{default: 0};
    gen = 1;
    repeat (n) @(posedge CLK);
    gen = 0;
    repeat (6) @(posedge CLK);
    gen = 1;
  endtask

  task wait_run(input logic v);
    int n;
    n = 0;
    while (CPU_RUN !== v && n < 3000) begin
      @(posedge CLK);
      n++;
    end
    if (n >= 3000) chk(v, CPU_RUN);
  endtask

  task pulse_wake;
    @(posedge CLK);
    WAKE_IRQ <= 1;
    @(posedge CLK);
    WAKE_IRQ <= 0;
  endtask

  task conclude;
    $display("compares %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (40000) @(posedge CLK);
    mismatches++;
    conclude;
  end

  // main sequence
  initial begin
    repeat (12) @(posedge CLK);
    SRST <= 0;
    wait_run(1);
    chk(4, wc);
    rd(clk_pwr_pkg::OFF_SRC_SEL, 0);
    rd(clk_pwr_pkg::OFF_PLL_CTRL, 0);
    rd(clk_pwr_pkg::OFF_PLL_STAT, 0);
    rd(clk_pwr_pkg::OFF_CPU_DIV, 0);
    rd(clk_pwr_pkg::OFF_PER_EN, 32'hf);
    rd(clk_pwr_pkg::OFF_PWR_CTRL, 32'h1);
    wr(6'h3c, 32'hffff);
    rd(6'h3c, 0);
    // only the enabled byte lane is written
    BYTEENABLE <= 4'h2;
    wr(clk_pwr_pkg::OFF_PLL_CFG, 32'h123456);
    BYTEENABLE <= 4'hf;
    rd(clk_pwr_pkg::OFF_PLL_CFG, 32'h3400);
    // undivided cpu and peripherals follow the rc ticks
    measure(300);
    chk(nt, nc);
    for (int i = 0; i < 4; i++) chk(nt, np[i]);
    chk(0, nu);
    // slower cpu, peripheral 2 stopped, peripheral 1 halved
    wr(clk_pwr_pkg::OFF_CPU_DIV, 1);
    wr(clk_pwr_pkg::OFF_PER_EN, 32'hb);
    wr(clk_pwr_pkg::OFF_PER_DIV, 32'h4);
    measure(300);
    near(nt / 2, nc);
    near(nt / 2, np[0]);
    near(nt / 4, np[1]);
    chk(0, np[2]);
    // idle stops the cpu, peripherals run on
    wr(clk_pwr_pkg::OFF_PWR_CTRL, 1);
    wait_run(0);
    rd(clk_pwr_pkg::OFF_PWR_CTRL, 32'h2);
    measure(300);
    chk(0, nc);
    near(nt / 2, np[3]);
    pulse_wake;
    wait_run(1);
    // rtc as source, the unused code refused
    wr(clk_pwr_pkg::OFF_CPU_DIV, 0);
    wr(clk_pwr_pkg::OFF_SRC_SEL, 2);
    wr(clk_pwr_pkg::OFF_SRC_SEL, 3);
    rd(clk_pwr_pkg::OFF_SRC_SEL, 2);
    src = 2;
    repeat (50) @(posedge CLK);
    measure(400);
    chk(nt, nc);
    wr(clk_pwr_pkg::OFF_SRC_SEL, 0);
    src = 0;
    repeat (80) @(posedge CLK);
    // pll fields at their limits, connect before lock stays bypassed
    wr(clk_pwr_pkg::OFF_PLL_CFG, 32'h7fffff);
    rd(clk_pwr_pkg::OFF_PLL_CFG, 32'h7fffff);
    wr(clk_pwr_pkg::OFF_PLL_CTRL, 3);
    rd(clk_pwr_pkg::OFF_PLL_STAT, 1);
    chk(0, PLL_LOCKED);
    measure(200);
    chk(nt, nc);
    near(206 / (clk_pwr_pkg::RST_CCO_PER + 1), nu);
    // sleep drops the pll and both dividers, wakes after 4 rc ticks
    wr(clk_pwr_pkg::OFF_CPU_DIV, 1);
    wr(clk_pwr_pkg::OFF_USB_DIV, 5);
    wr(clk_pwr_pkg::OFF_PWR_CTRL, 2);
    wait_run(0);
    gen = 0;
    rd(clk_pwr_pkg::OFF_PLL_CTRL, 0);
    rd(clk_pwr_pkg::OFF_CPU_DIV, 0);
    rd(clk_pwr_pkg::OFF_USB_DIV, 0);
    rd(clk_pwr_pkg::OFF_PWR_CTRL, 32'h4);
    repeat (6) @(posedge CLK);
    wc = 0;
    pulse_wake;
    gen = 1;
    wait_run(1);
    chk(4, wc);
    // flash start-up counted in rc ticks since reset
    for (int n = 0; n < 3000 && FLASH_READY !== 1'b1; n++) @(posedge CLK);
    chk(400, fc);
    // main oscillator: enable, await its wake-up count, then select
    wr(clk_pwr_pkg::OFF_OSC_CTRL, 1);
    rd(clk_pwr_pkg::OFF_STATUS, 32'h12);
    for (int n = 0; n < 6000 && q[0] !== 1'b1; n++)
      bus(0, clk_pwr_pkg::OFF_STATUS, 0);
    chk(32'h13, q);
    wr(clk_pwr_pkg::OFF_SRC_SEL, 1);
    src = 1;
    repeat (50) @(posedge CLK);
    measure(300);
    chk(nt, nc);
    // power-down wakes on the rc, main off, flash restarts
    wr(clk_pwr_pkg::OFF_PWR_CTRL, 4);
    wait_run(0);
    rd(clk_pwr_pkg::OFF_PWR_CTRL, 32'h8);
    pulse_wake;
    src = 0;
    wait_run(1);
    rd(clk_pwr_pkg::OFF_SRC_SEL, 0);
    rd(clk_pwr_pkg::OFF_OSC_CTRL, 0);
    chk(0, FLASH_READY);
    for (int n = 0; n < 4000 && FLASH_READY !== 1'b1; n++) @(posedge CLK);
    chk(800, fc);
    // deep power-down wakes as from a full reset
    wr(clk_pwr_pkg::OFF_PWR_CTRL, 8);
    wait_run(0);
    rd(clk_pwr_pkg::OFF_PWR_CTRL, 32'h10);
    pulse_wake;
    wait_run(1);
    rd(clk_pwr_pkg::OFF_PER_EN, 32'hf);
    chk(0, FLASH_READY);
    conclude;
  end
endmodule
